/* File: design/itrc_pkg.sv */
// Constants, types and command codes for the integration time and rate control block.
// Assumes a command parser upstream that delivers decoded commands and numeric arguments.
// Functional notes
// RULE1 - Pressure period hold: measure period in microseconds, keep it, stay silent.
// RULE2 - Temperature hold: measure period, convert in chosen unit, keep it, await dump.
// RULE3 - Temperature period hold: measure period in microseconds, keep it, stay silent.
// RULE4 - Held sample leaves only on a dump command; any other command discards it.
// RULE5 - Integration is time based; legacy counts convert to equivalent times.
// RULE6 - Pressure gate in 1 ms steps, 1..290000 or 1..72500 extended, default 666.
// RULE7 - Temperature gate same ranges as pressure gate, default 666.
// RULE8 - Pressure gate write copies into temperature gate; reverse does not.
// RULE9 - Simultaneous integration: acquisition time is the larger gate time.
// RULE10 - Legacy pressure count accepts 1..16383, default 238, readable and writable.
// RULE11 - Legacy temperature count accepts 1..65535, default 952.
// RULE12 - Legacy pressure count write sets temperature count to four times it.
// RULE13 - Legacy pressure count about 3 ms per step, temperature about 1 ms.
// RULE14 - Output rate in hertz accepts 1..180; slower rates need the pressure gate.
// RULE15 - Output rate defaults to zero; zero hands control back to pressure gate.
// RULE16 - Standard resolution: nonzero rate sets pressure gate for best resolution.
// RULE17 - Nano mode: rate governs data rate only; resolution from nano setting.
// RULE18 - Rate affects only streaming commands; polled and hold use pressure gate.
// RULE19 - Host names the command; device checks baud and length, answers OK.
// RULE20 - Unreachable rate answers ERROR and keeps the previous rate value.
// RULE21 - Host should keep gates equal and re-issue rate after config change.
// RULE22 - Host sends the enable write prefix before each setting write.
package itrc_pkg;

  // Gate limits and defaults in ms
  localparam logic [18:0] GATE_MIN      = 19'h00001;
  localparam logic [18:0] GATE_MAX_STD  = 19'h46cd0;  // 290000
  localparam logic [18:0] GATE_MAX_EXT  = 19'h11b34;  // 72500
  localparam logic [18:0] GATE_DEFAULT  = 19'h0029a;  // 666

  // Legacy counts
  localparam logic [15:0] BARO_MAX      = 16'h3fff;   // 16383
  localparam logic [15:0] BARO_DEFAULT  = 16'h00ee;   // 238
  localparam logic [15:0] THERM_MAX     = 16'hffff;
  localparam logic [15:0] THERM_DEFAULT = 16'h03b8;   // 952
  localparam int          THERM_PER_BARO = 4;
  localparam int          BARO_STEP_MS   = 3;
  localparam int          THERM_STEP_MS  = 1;

  // Output rate
  localparam logic [7:0]  RATE_MIN      = 8'h01;
  localparam logic [7:0]  RATE_MAX      = 8'hb4;      // 180
  localparam logic [7:0]  RATE_DEFAULT  = 8'h00;

  // Timebase: 25 MHz reference, 1 ms tick
  localparam int          CLK_HZ        = 25000000;
  localparam int          TICK_MS       = 1;
  localparam int          CYC_PER_MS    = CLK_HZ / 1000 * TICK_MS;
  localparam int          MS_PER_S      = 1000;
  // Character time in bit periods (start, 8 data, stop)
  localparam int          BITS_PER_CHAR = 10;

  // Decoded command codes
  typedef enum logic [3:0] {
    ITRC_CMD_NONE,
    ITRC_CMD_HOLD_PRESSURE_PERIOD,
    ITRC_CMD_HOLD_SENSOR_TEMPERATURE,
    ITRC_CMD_HOLD_TEMPERATURE_PERIOD,
    ITRC_CMD_DUMP_HELD_VALUE,
    ITRC_CMD_DUMP_IN_LOOP_ORDER,
    ITRC_CMD_SET_PRESSURE_GATE,
    ITRC_CMD_SET_TEMPERATURE_GATE,
    ITRC_CMD_SET_BARO_COUNT,
    ITRC_CMD_SET_THERMAL_COUNT,
    ITRC_CMD_SET_OUTPUT_RATE,
    ITRC_CMD_STREAM,
    ITRC_CMD_POLL,
    ITRC_CMD_OTHER
  } itrc_cmd_t;

  // Which measurement a hold collects
  typedef enum logic [1:0] {
    ITRC_HOLD_PPER,
    ITRC_HOLD_TEMP,
    ITRC_HOLD_TPER
  } itrc_hold_kind_t;

  // Command from the parser
  typedef struct packed {
    logic      valid;
    itrc_cmd_t code;
    logic [18:0] arg;
    logic [15:0] resp_chars;
  } itrc_req_t;

  // Answer to an output rate write
  typedef struct packed {
    logic valid;
    logic ok;
    logic error;
  } itrc_ack_t;

  // Measurement request to the front end
  typedef struct packed {
    logic        start;
    logic        want_p;
    logic        want_t;
    logic        temp_unit_c;
    logic [18:0] p_ms;
    logic [18:0] t_ms;
  } itrc_meas_t;

endpackage : itrc_pkg

/* File: design/itrc_core.sv */
// Command side of the integration time and rate control block.
// Assumes decoded commands arrive as one-cycle requests after addressing and write enable;
// the measurement front end reports results with a one-cycle done strobe.
`timescale 1ns/1ps
module itrc_core
  import itrc_pkg::*;
(
  // Clock and reset
  input  wire logic        i_ref_clk,
  input  wire logic        i_arst_n,
  // Decoded command input
  input  wire itrc_req_t   i_req,
  // Configuration levels
  input  wire logic        i_extended_range_select,
  input  wire logic        i_temp_unit_select,
  input  wire logic        i_nano_mode,
  input  wire logic        i_simultaneous,
  input  wire logic [17:0] i_baud_rate,
  // Measurement front end
  input  wire logic        i_meas_done,
  input  wire logic [31:0] i_meas_value,
  output itrc_meas_t       o_meas,
  // Held value output
  output logic             o_dump_valid,
  output logic [31:0]      o_dump_value,
  output logic             o_hold_busy,
  // Setting answers and read back
  output itrc_ack_t        o_ack,
  output logic [18:0]      o_pressure_gate_ms,
  output logic [18:0]      o_temperature_gate_ms,
  output logic [15:0]      o_old_baro_gate_count,
  output logic [15:0]      o_old_thermal_gate_count,
  output logic [7:0]       o_output_rate_hz,
  // Effective timing
  output logic [18:0]      o_acq_time_ms,
  output logic             o_rate_tick
);

  typedef enum logic [1:0] {
    ITRC_ST_IDLE,
    ITRC_ST_MEASURE,
    ITRC_ST_HELD
  } itrc_state_t;

  // Range check on a gate value
  function automatic logic gate_ok(input logic [18:0] v, input logic ext);
    gate_ok = (v >= GATE_MIN) && (v <= (ext ? GATE_MAX_EXT : GATE_MAX_STD));
  endfunction : gate_ok

  // Larger of two times
  function automatic logic [18:0] max19(input logic [18:0] a, input logic [18:0] b);
    max19 = (a > b) ? a : b;
  endfunction : max19

  // Milliseconds per output period at a rate
  function automatic logic [18:0] period_ms(input logic [7:0] hz);
    period_ms = (hz == RATE_DEFAULT) ? GATE_MIN : 19'(MS_PER_S / int'(hz));
  endfunction : period_ms

  logic        req_v;
  itrc_cmd_t   code;
  logic [18:0] arg;
  assign req_v = i_req.valid;
  assign code  = i_req.code;
  assign arg   = i_req.arg;

  logic [18:0]     p_gate_q;
  logic [18:0]     t_gate_q;
  logic [15:0]     baro_q;
  logic [15:0]     therm_q;
  logic [7:0]      rate_q;
  itrc_state_t     state_q;
  itrc_hold_kind_t kind_q;
  logic            dump_pending_q;
  logic [31:0]     held_q;
  logic [24:0]     ms_cnt_q;
  logic [18:0]     rate_ms_q;
  logic            ms_tick;

  // Rate feasibility: chars*bits*rate must fit in the baud rate
  logic [7:0]  rate_arg;
  logic [47:0] need_bits;
  logic        rate_feasible;
  logic        rate_arg_ok;
  assign rate_arg      = arg[7:0];
  assign need_bits     = 48'(i_req.resp_chars) * 48'(BITS_PER_CHAR) * 48'(rate_arg);
  assign rate_arg_ok   = (arg[18:8] == '0) && (rate_arg <= RATE_MAX);
  assign rate_feasible = (rate_arg == RATE_DEFAULT) ||
                         ((rate_arg >= RATE_MIN) && (need_bits <= 48'(i_baud_rate)));

  // Gate settings; a pressure write mirrors into temperature
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      p_gate_q <= GATE_DEFAULT;                                  // see RULE6
      t_gate_q <= GATE_DEFAULT;                                  // see RULE7
    end else if (req_v) begin
      case (code)
        ITRC_CMD_SET_PRESSURE_GATE: begin
          if (gate_ok(arg, i_extended_range_select)) begin       // see RULE6
            p_gate_q <= arg;
            t_gate_q <= arg;                                     // see RULE8
          end
        end
        ITRC_CMD_SET_TEMPERATURE_GATE: begin
          if (gate_ok(arg, i_extended_range_select)) begin       // see RULE7
            t_gate_q <= arg;                                     // see RULE8
          end
        end
        // Legacy counts become time windows at their step size
        ITRC_CMD_SET_BARO_COUNT: begin
          if (arg >= GATE_MIN && arg <= 19'(BARO_MAX)) begin     // see RULE5
            p_gate_q <= 19'(arg * BARO_STEP_MS);                 // see RULE13
            t_gate_q <= 19'(arg * THERM_PER_BARO * THERM_STEP_MS);
          end
        end
        ITRC_CMD_SET_THERMAL_COUNT: begin
          if (arg >= GATE_MIN && arg <= 19'(THERM_MAX)) begin
            t_gate_q <= 19'(arg * THERM_STEP_MS);                // see RULE13
          end
        end
        // Nonzero rate in standard mode sets the gate to fill one period
        ITRC_CMD_SET_OUTPUT_RATE: begin
          if (!i_nano_mode && rate_arg_ok && rate_feasible &&
              rate_arg != RATE_DEFAULT) begin
            p_gate_q <= period_ms(rate_arg);                     // see RULE16
            t_gate_q <= period_ms(rate_arg);
          end
        end
        default: begin
        end
      endcase
    end
  end

  // Legacy count settings kept for read back
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      baro_q  <= BARO_DEFAULT;                                   // see RULE10
      therm_q <= THERM_DEFAULT;                                  // see RULE11
    end else if (req_v && code == ITRC_CMD_SET_BARO_COUNT &&
                 arg >= GATE_MIN && arg <= 19'(BARO_MAX)) begin  // see RULE10
      baro_q  <= arg[15:0];
      therm_q <= 16'(arg * THERM_PER_BARO);                      // see RULE12
    end else if (req_v && code == ITRC_CMD_SET_THERMAL_COUNT &&
                 arg >= GATE_MIN && arg <= 19'(THERM_MAX)) begin // see RULE11
      therm_q <= arg[15:0];
    end
  end

  // Output rate; refused values keep the old setting
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rate_q <= RATE_DEFAULT;                                    // see RULE15
    end else if (req_v && code == ITRC_CMD_SET_OUTPUT_RATE &&
                 rate_arg_ok && rate_feasible) begin             // see RULE14 RULE20
      rate_q <= rate_arg;
    end
  end

  // Answer to a rate write: OK or ERROR appended to the echo
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_ack <= '0;
    end else begin
      o_ack.valid <= req_v && code == ITRC_CMD_SET_OUTPUT_RATE;
      o_ack.ok    <= req_v && code == ITRC_CMD_SET_OUTPUT_RATE &&
                     rate_arg_ok && rate_feasible;               // see RULE19
      o_ack.error <= req_v && code == ITRC_CMD_SET_OUTPUT_RATE &&
                     !(rate_arg_ok && rate_feasible);            // see RULE20
    end
  end

  // Sample and hold sequence
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_q        <= ITRC_ST_IDLE;
      kind_q         <= ITRC_HOLD_PPER;
      dump_pending_q <= 1'b0;
      held_q         <= '0;
      o_dump_valid   <= 1'b0;
      o_dump_value   <= '0;
    end else begin
      o_dump_valid <= 1'b0;
      // New command: any non-dump command cancels a hold
      if (req_v) begin
        case (code)
          ITRC_CMD_HOLD_PRESSURE_PERIOD: begin
            state_q        <= ITRC_ST_MEASURE;                   // see RULE1
            kind_q         <= ITRC_HOLD_PPER;
            dump_pending_q <= 1'b0;
          end
          ITRC_CMD_HOLD_SENSOR_TEMPERATURE: begin
            state_q        <= ITRC_ST_MEASURE;                   // see RULE2
            kind_q         <= ITRC_HOLD_TEMP;
            dump_pending_q <= 1'b0;
          end
          ITRC_CMD_HOLD_TEMPERATURE_PERIOD: begin
            state_q        <= ITRC_ST_MEASURE;                   // see RULE3
            kind_q         <= ITRC_HOLD_TPER;
            dump_pending_q <= 1'b0;
          end
          ITRC_CMD_DUMP_HELD_VALUE, ITRC_CMD_DUMP_IN_LOOP_ORDER: begin
            if (state_q == ITRC_ST_HELD) begin
              o_dump_valid <= 1'b1;                              // see RULE4
              o_dump_value <= held_q;
              state_q      <= ITRC_ST_IDLE;
            end else if (state_q == ITRC_ST_MEASURE) begin
              dump_pending_q <= 1'b1;                            // send when ready
            end
          end
          default: begin
            state_q        <= ITRC_ST_IDLE;                      // see RULE4
            dump_pending_q <= 1'b0;
          end
        endcase
      end else if (state_q == ITRC_ST_MEASURE && i_meas_done) begin
        // Result is kept silently unless a dump already waits
        held_q <= i_meas_value;                                  // see RULE1 RULE3
        if (dump_pending_q) begin
          o_dump_valid   <= 1'b1;
          o_dump_value   <= i_meas_value;
          dump_pending_q <= 1'b0;
          state_q        <= ITRC_ST_IDLE;
        end else begin
          state_q <= ITRC_ST_HELD;
        end
      end
    end
  end

  // Measurement start: hold and poll use the gate, never the rate
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_meas <= '0;
    end else begin
      o_meas.start       <= req_v && (code == ITRC_CMD_HOLD_PRESSURE_PERIOD ||
                                      code == ITRC_CMD_HOLD_SENSOR_TEMPERATURE ||
                                      code == ITRC_CMD_HOLD_TEMPERATURE_PERIOD ||
                                      code == ITRC_CMD_POLL);  // see RULE18
      o_meas.want_p      <= req_v && (code == ITRC_CMD_HOLD_PRESSURE_PERIOD ||
                                      code == ITRC_CMD_POLL);
      o_meas.want_t      <= req_v && code != ITRC_CMD_HOLD_PRESSURE_PERIOD;
      o_meas.temp_unit_c <= i_temp_unit_select;                  // see RULE2
      o_meas.p_ms        <= p_gate_q;                            // see RULE5
      o_meas.t_ms        <= t_gate_q;
    end
  end

  // Acquisition time of one measurement
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_acq_time_ms <= GATE_DEFAULT;
    end else if (i_simultaneous) begin
      o_acq_time_ms <= max19(p_gate_q, t_gate_q);                // see RULE9
    end else begin
      o_acq_time_ms <= 19'(p_gate_q + t_gate_q);
    end
  end

  // Millisecond divider
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ms_cnt_q <= '0;
    end else if (ms_tick) begin
      ms_cnt_q <= '0;
    end else begin
      ms_cnt_q <= ms_cnt_q + 25'h0000001;
    end
  end
  assign ms_tick = (ms_cnt_q == 25'(CYC_PER_MS - 1));

  // Streaming pace: fixed rate when set, else the acquisition time; nano keeps gate for resolution
  logic [18:0] stream_ms;
  assign stream_ms = (rate_q != RATE_DEFAULT) ? period_ms(rate_q)  // see RULE16 RULE17
                                              : o_acq_time_ms;     // see RULE15
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rate_ms_q   <= '0;
      o_rate_tick <= 1'b0;
    end else begin
      o_rate_tick <= 1'b0;
      if (ms_tick) begin
        if (rate_ms_q + 19'h00001 >= stream_ms) begin
          rate_ms_q   <= '0;
          o_rate_tick <= 1'b1;                                   // see RULE18
        end else begin
          rate_ms_q <= rate_ms_q + 19'h00001;
        end
      end
    end
  end

  // Read back
  assign o_hold_busy              = (state_q != ITRC_ST_IDLE);
  assign o_pressure_gate_ms       = p_gate_q;
  assign o_temperature_gate_ms    = t_gate_q;
  assign o_old_baro_gate_count    = baro_q;
  assign o_old_thermal_gate_count = therm_q;
  assign o_output_rate_hz         = rate_q;

endmodule : itrc_core

/* File: sim/itrc_core_monitor.sv */
// Checker on the core ports: setting writes, rate answers, holds.
// Assumes one bind per core instance; sees only top-level ports.
`timescale 1ns/1ps
module itrc_core_monitor
  import itrc_pkg::*;
(
  // Clock, reset and inputs
  input wire logic        i_ref_clk,
  input wire logic        i_arst_n,
  input wire itrc_req_t   i_req,
  input wire logic        i_extended_range_select,
  input wire logic        i_nano_mode,
  input wire logic [17:0] i_baud_rate,
  // Outputs watched
  input wire itrc_meas_t  o_meas,
  input wire logic        o_dump_valid,
  input wire logic        o_hold_busy,
  input wire itrc_ack_t   o_ack,
  input wire logic [18:0] o_pressure_gate_ms,
  input wire logic [18:0] o_temperature_gate_ms,
  input wire logic [15:0] o_old_baro_gate_count,
  input wire logic [15:0] o_old_thermal_gate_count,
  input wire logic [7:0]  o_output_rate_hz
);
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_arst_n);

  // Request kinds; feasibility test is evaluated only for legal rates
  logic        set_p;
  logic        set_b;
  logic        set_h;
  logic        hold;
  logic        feas;
  logic [18:0] top;
  logic [18:0] std_ms;
  assign set_p  = i_req.valid && (i_req.code == ITRC_CMD_SET_PRESSURE_GATE);
  assign set_b  = i_req.valid && (i_req.code == ITRC_CMD_SET_BARO_COUNT);
  assign set_h  = i_req.valid && (i_req.code == ITRC_CMD_SET_OUTPUT_RATE);
  assign hold   = i_req.valid && (i_req.code >= ITRC_CMD_HOLD_PRESSURE_PERIOD) &&
                  (i_req.code <= ITRC_CMD_HOLD_TEMPERATURE_PERIOD);
  assign top    = i_extended_range_select ? GATE_MAX_EXT : GATE_MAX_STD;
  assign feas   = (i_req.arg <= 19'(RATE_MAX)) &&
                  (32'(i_req.resp_chars) * 32'd10 * 32'(i_req.arg) <= 32'(i_baud_rate));
  // Divisor guarded so a zero rate never divides
  assign std_ms = 19'(32'd1000 / ((i_req.arg == 19'h0) ? 32'd1 : 32'(i_req.arg)));

  a_pgate_copy: assert property (set_p && i_req.arg >= GATE_MIN && i_req.arg <= top |=>
    o_pressure_gate_ms == $past(i_req.arg) && o_temperature_gate_ms == $past(i_req.arg))
    else $error("pressure gate write not copied");
  a_baro_quad: assert property (set_b && i_req.arg != 0 && i_req.arg <= 19'(BARO_MAX) |=>
    o_old_thermal_gate_count == {$past(i_req.arg[13:0]), 2'b00} &&
    o_old_baro_gate_count == $past(i_req.arg[15:0])) else $error("baro count not quadrupled");
  a_rate_accept: assert property (set_h && feas |=> o_ack.valid && o_ack.ok &&
    !o_ack.error && o_output_rate_hz == $past(i_req.arg[7:0])) else $error("rate not accepted");
  a_rate_refuse: assert property (set_h && !feas |=> o_ack.valid && o_ack.error &&
    !o_ack.ok && $stable(o_output_rate_hz)) else $error("rate not refused");
  a_std_gate: assert property (set_h && feas && !i_nano_mode && i_req.arg != 0 |=>
    o_pressure_gate_ms == $past(std_ms)) else $error("rate did not set gate");
  a_nano_gate: assert property (set_h && i_nano_mode |=>
    $stable(o_pressure_gate_ms)) else $error("nano rate changed gate");
  a_hold_start: assert property (hold |=> o_meas.start && o_hold_busy)
    else $error("hold did not start");
  a_dump_cause: assert property (o_dump_valid |-> $past(o_hold_busy) && !o_hold_busy)
    else $error("dump without hold");

  c_rate_ok: cover property (set_h && feas ##1 o_ack.ok);
  c_rate_err: cover property (set_h && !feas ##1 o_ack.error);
  c_dump: cover property (o_hold_busy ##1 o_dump_valid);
endmodule : itrc_core_monitor

bind itrc_core itrc_core_monitor u_mon (
  .i_ref_clk(i_ref_clk), .i_arst_n(i_arst_n), .i_req(i_req),
  .i_extended_range_select(i_extended_range_select), .i_nano_mode(i_nano_mode),
  .i_baud_rate(i_baud_rate), .o_meas(o_meas), .o_dump_valid(o_dump_valid),
  .o_hold_busy(o_hold_busy), .o_ack(o_ack), .o_pressure_gate_ms(o_pressure_gate_ms),
  .o_temperature_gate_ms(o_temperature_gate_ms),
  .o_old_baro_gate_count(o_old_baro_gate_count),
  .o_old_thermal_gate_count(o_old_thermal_gate_count), .o_output_rate_hz(o_output_rate_hz)
);

/* File: sim/itrc_front_model.sv */
// Behavioural measurement front end answering each start with one result.
// Assumes one measurement at a time; delay and sample come from the bench.
`timescale 1ns/1ps
module itrc_front_model
  import itrc_pkg::*;
(
  // Clock and request
  input  wire logic        i_ref_clk,
  input  wire itrc_meas_t  i_meas,
  input  wire logic [7:0]  i_delay,
  input  wire logic [31:0] i_sample,
  // Result
  output logic             o_done,
  output logic [31:0]      o_value
);
  // Result after a settable wait; stale data flips so nothing reads it by luck
  initial begin
    o_done  = 1'b0;
    o_value = 32'h0;
    forever begin
      @(posedge i_ref_clk);
      if (i_meas.start === 1'b1) begin
        repeat (i_delay + 1) @(negedge i_ref_clk);
        o_done  = 1'b1;
        o_value = i_sample;
        @(negedge i_ref_clk);
        o_done  = 1'b0;
        o_value = ~i_sample;
      end
    end
  end
endmodule : itrc_front_model

/* File: sim/itrc_core_tb.sv */
// Self-checking bench for the integration time and rate control core.
// Assumes the front end model answers each measurement start.
`timescale 1ns/1ps
module itrc_core_tb;
  import itrc_pkg::*;
  // Stimulus, observed outputs and expectations
  logic        clk;
  logic        arst_n;
  itrc_req_t   req;
  logic        ext;
  logic        unit;
  logic        nano;
  logic        simul;
  logic [17:0] baud;
  logic        done;
  logic [31:0] mval;
  logic [7:0]  dly;
  logic [31:0] smp;
  itrc_meas_t  meas;
  logic        dv;
  logic [31:0] dval;
  logic        busy;
  itrc_ack_t   ack;
  itrc_ack_t   ack_s;
  logic        st_s;
  logic        dv_s;
  logic [18:0] pg;
  logic [18:0] tg;
  logic [18:0] acq;
  logic [15:0] bc;
  logic [15:0] tc;
  logic [7:0]  rt;
  logic [18:0] e_p;
  logic [18:0] e_t;
  logic [15:0] e_b;
  logic [15:0] e_c;
  logic [7:0]  e_r;
  int          err_count;
  int          cmp_count;
  int          cyc;
  logic [18:0] gc [6] = '{19'd290000, 19'd290001, 19'd0, 19'd1, 19'd72501, 19'd72500};
  logic [18:0] rc [5] = '{19'd20, 19'd40, 19'd181, 19'd0, 19'd180};

  itrc_core u_dut (
    .i_ref_clk(clk), .i_arst_n(arst_n), .i_req(req), .i_extended_range_select(ext),
    .i_temp_unit_select(unit), .i_nano_mode(nano), .i_simultaneous(simul),
    .i_baud_rate(baud), .i_meas_done(done), .i_meas_value(mval), .o_meas(meas),
    .o_dump_valid(dv), .o_dump_value(dval), .o_hold_busy(busy), .o_ack(ack),
    .o_pressure_gate_ms(pg), .o_temperature_gate_ms(tg), .o_old_baro_gate_count(bc),
    .o_old_thermal_gate_count(tc), .o_output_rate_hz(rt), .o_acq_time_ms(acq),
    .o_rate_tick()
  );
  itrc_front_model u_fe (
    .i_ref_clk(clk), .i_meas(meas), .i_delay(dly), .i_sample(smp), .o_done(done),
    .o_value(mval)
  );

  // 25 MHz clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Hang guard, far above the planned run length
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      finish_test();
    end
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch %s expected %0h seen %0h", what, exp, got);
    end
  endtask : chk

  // One prefixed set or measurement command; captures its answer one cycle later, returns two cycles later
  task automatic wr(input itrc_cmd_t c, input logic [18:0] a, input logic [15:0] n);
    req = '{1'b1, c, a, n};
    @(negedge clk);
    // One-cycle answers stand only now, so they are captured here
    ack_s = ack;
    st_s  = meas.start;
    dv_s  = dv;
    req = '0;
    @(negedge clk);
  endtask : wr

  task automatic chk_cfg();
    chk("pressure_gate", e_p, pg);
    chk("temperature_gate", e_t, tg);
    chk("baro_count", e_b, bc);
    chk("thermal_count", e_c, tc);
    chk("rate", e_r, rt);
  endtask : chk_cfg

  task automatic wait_done();
    for (int j = 0; j < 300 && done !== 1'b1; j++) @(posedge clk);
    @(negedge clk);
  endtask : wait_done

  function automatic logic rate_ok(input logic [18:0] r, input logic [15:0] n);
    return (r <= 19'd180) && (32'(n) * 32'd10 * 32'(r) <= 32'(baud));
  endfunction : rate_ok

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : finish_test

  // Main sequence
  initial begin
    logic [18:0] v;
    logic [15:0] n;
    logic        is_p;
    logic        ok;
    arst_n = 1'b0;
    req    = '0;
    ext    = 1'b0;
    unit   = 1'b0;
    nano   = 1'b0;
    simul  = 1'b1;
    baud   = 18'd9600;
    dly    = 8'h2;
    smp    = 32'h0;
    {e_p, e_t, e_b, e_c, e_r} = {GATE_DEFAULT, GATE_DEFAULT, BARO_DEFAULT, THERM_DEFAULT, 8'h0};
    void'($urandom(97));
    repeat (20) @(negedge clk);
    arst_n = 1'b1;
    @(negedge clk);
    chk_cfg();
    // Gate writes: range corners first, then random values
    for (int k = 0; k < 14; k++) begin
      ext  = (k == 4 || k == 5);
      is_p = (k < 6) || k[0];
      v    = (k < 6) ? gc[k] : 19'(1 + $urandom % 290000);
      wr(is_p ? ITRC_CMD_SET_PRESSURE_GATE : ITRC_CMD_SET_TEMPERATURE_GATE, v, 16'h0);
      if (v != 0 && v <= (ext ? GATE_MAX_EXT : GATE_MAX_STD)) begin
        e_t = v;
        if (is_p) e_p = v;
      end
      chk_cfg();
    end
    // Legacy counts: corners interleaved with random values
    for (int k = 0; k < 8; k++) begin
      is_p = (k < 4) || k[0];
      v = (k == 0) ? 19'd16383 : (k == 1) ? 19'd16384 : (k == 2 || k == 4) ? 19'd0 :
          (k == 6) ? 19'd65535 : 19'(1 + $urandom % 16383);
      wr(is_p ? ITRC_CMD_SET_BARO_COUNT : ITRC_CMD_SET_THERMAL_COUNT, v, 16'h0);
      if (v != 0 && is_p && v <= 19'd16383) begin
        e_b = v[15:0];
        e_c = 16'(4 * v);
        e_p = 19'(3 * v);
        e_t = 19'(4 * v);
      end else if (v != 0 && !is_p) begin
        e_c = v[15:0];
        e_t = v;
      end
      chk_cfg();
    end
    // Acquisition time, serial then simultaneous
    wr(ITRC_CMD_SET_PRESSURE_GATE, 19'd100, 16'h0);
    wr(ITRC_CMD_SET_TEMPERATURE_GATE, 19'd300, 16'h0);
    {e_p, e_t} = {19'd100, 19'd300};
    simul = 1'b0;
    repeat (2) @(negedge clk);
    chk("acq_sum", 32'd400, acq);
    simul = 1'b1;
    repeat (2) @(negedge clk);
    chk("acq_max", 32'd300, acq);
    // Holds of each kind; the last three dump before the result is in
    for (int k = 0; k < 6; k++) begin
      unit = k[0];
      smp  = $urandom;
      dly  = 8'(2 + $urandom % 8);
      wr(itrc_cmd_t'(4'(1 + k % 3)), 19'h0, 16'h0);
      chk("meas_start", 32'h1, st_s);
      chk("temp_unit", 32'(unit), meas.temp_unit_c);
      if (k < 3) begin
        wait_done();
        chk("silent", 32'h0, dv);
      end
      wr(k[0] ? ITRC_CMD_DUMP_HELD_VALUE : ITRC_CMD_DUMP_IN_LOOP_ORDER, 19'h0, 16'h0);
      for (int j = 0; j < 40 && dv_s !== 1'b1 && dv !== 1'b1; j++) @(negedge clk);
      chk("dump_value", smp, dval);
      @(negedge clk);
      chk("busy", 32'h0, busy);
    end
    // A setting write between hold and dump throws the sample away
    wr(ITRC_CMD_HOLD_PRESSURE_PERIOD, 19'h0, 16'h0);
    wait_done();
    wr(ITRC_CMD_SET_TEMPERATURE_GATE, 19'd777, 16'h0);
    e_t = 19'd777;
    wr(ITRC_CMD_DUMP_HELD_VALUE, 19'h0, 16'h0);
    chk("dump_dropped", 32'h0, dv_s);
    // Rate writes: corners at 9600 baud, then random lengths, nano last
    for (int k = 0; k < 12; k++) begin
      nano = (k >= 8);
      v    = (k < 5) ? rc[k] : 19'($urandom % 200);
      n    = (k == 4) ? 16'd1 : (k < 5) ? 16'd48 : 16'(1 + $urandom % 60);
      ok   = rate_ok(v, n);
      wr(ITRC_CMD_SET_OUTPUT_RATE, v, n);
      chk("ack", {29'h0, 1'b1, ok, !ok}, {29'h0, ack_s});
      if (ok) begin
        e_r = v[7:0];
        if (!nano && v != 0) e_p = 19'(1000 / v);
        if (!nano && v != 0) e_t = e_p;
      end
      chk_cfg();
    end
    // A hold still measures over the pressure gate
    wr(ITRC_CMD_HOLD_PRESSURE_PERIOD, 19'h0, 16'h0);
    chk("hold_gate", e_p, meas.p_ms);
    finish_test();
  end
endmodule : itrc_core_tb
